// File: rtl/rx_cfg_pkg.sv
// shared constants, register map and carrier types of the receive filter configuration bank
`default_nettype none
package rx_cfg_pkg;
   // register indexes; the byte address on the bus is four times the index
   localparam int IDX_W = 7;
   localparam logic [6:0] IDX_CTRL_MASK0 = 7'h42;
   localparam logic [6:0] IDX_CTRL_MASK1 = 7'h43;
   localparam logic [6:0] IDX_CTRL_MASK2 = 7'h44;
   localparam logic [6:0] IDX_CTRL_MASK3 = 7'h45;
   localparam logic [6:0] IDX_CTRL_REF3 = 7'h46;
   localparam logic [6:0] IDX_CTRL_REF2 = 7'h47;
   localparam logic [6:0] IDX_CTRL_REF1 = 7'h48;
   localparam logic [6:0] IDX_CTRL_REF0 = 7'h49;
   localparam logic [6:0] IDX_PEER_SOURCE_MASK = 7'h4A;
   localparam logic [6:0] IDX_PEER_ADDRESS = 7'h4B;
   localparam logic [6:0] IDX_ALL_STATIONS = 7'h4C;
   localparam logic [6:0] IDX_GROUP_ADDRESS = 7'h4D;
   localparam logic [6:0] IDX_OWN_ADDRESS = 7'h4E;
   localparam logic [6:0] IDX_FILTER_OPTIONS = 7'h4F;
   localparam logic [6:0] IDX_PROTOCOL_HI = 7'h50;
   localparam logic [6:0] IDX_PROTOCOL_MID = 7'h51;
   localparam logic [6:0] IDX_PROTOCOL_LO = 7'h52;
   localparam logic [6:0] IDX_TIMEOUT_PRESCALE = 7'h53;
   localparam logic [6:0] IDX_TIMEOUT_COUNT = 7'h54;
   localparam int NUM_REGS = 19;
   localparam int SLOT_W = 5;
   // reset values: zero, and those of the bytes that do not reset to zero
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_FILTER_OPTIONS = 8'h70;
   localparam logic [7:0] RST_PROTOCOL_HI = 8'h02;
   localparam logic [7:0] RST_PROTOCOL_LO = 8'h08;
   localparam logic [7:0] RST_TIMEOUT_PRESCALE = 8'h01;
   // filter option bits
   localparam int OPT_CRC_CHECK = 0;
   localparam int OPT_ALL_STATIONS = 1;
   localparam int OPT_GROUP = 2;
   localparam int OPT_OWN = 3;
   localparam int OPT_SOURCE = 4;
   localparam int OPT_CONTROL = 5;
   localparam int OPT_OR_SELECT = 6;
   // protocol high byte bits
   localparam int HI_CS_GATE = 7;
   localparam int HI_SQI_GATE = 6;
   localparam int HI_PQI_GATE = 5;
   localparam int HI_SEQ_MSB = 4;
   localparam int HI_SEQ_LSB = 3;
   localparam int HI_RC_CAL = 2;
   localparam int HI_SYNTH_CAL = 1;
   localparam int HI_DUTY = 0;
   // protocol middle byte bits
   localparam int MID_RELOAD_SYNC = 7;
   localparam int MID_ACK_PAYLOAD = 6;
   localparam int MID_SEED = 3;
   localparam int MID_ACCESS = 2;
   localparam int MID_PERSISTENT = 1;
   localparam int MID_AUTO_FILTER = 0;
   // protocol low byte bits
   localparam int LO_RETX_MSB = 7;
   localparam int LO_RETX_LSB = 4;
   localparam int LO_NO_ACK = 3;
   localparam int LO_AUTO_ACK = 2;
   localparam int LO_PERSISTENT_RECEIVE_EN = 1;
   localparam int LO_PERSISTENT_TRANSMIT_EN = 0;
   // receive timeout timebase
   localparam int CLOCK_PERIOD_NS = 4;
   localparam int TIMEOUT_TICK_NS = 1000;
   localparam int TICK_CYCLES = (TIMEOUT_TICK_NS / CLOCK_PERIOD_NS < 1) ? 1 : TIMEOUT_TICK_NS / CLOCK_PERIOD_NS;
   localparam int TICK_W = 8;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef struct packed {
      logic [7:0] dest;
      logic [7:0] source;
      logic [3:0][7:0] ctrl;
      logic crc_ok;
   } rx_pkt_s;

   typedef struct packed {
      logic auto_en;
      logic crc_check;
      logic own_en;
      logic group_en;
      logic all_en;
      logic source_en;
      logic ctrl_en;
      logic [7:0] own;
      logic [7:0] group;
      logic [7:0] all;
      logic [7:0] peer;
      logic [7:0] source_mask;
      logic [3:0][7:0] ctrl_ref;
      logic [3:0][7:0] ctrl_mask;
   } filter_cfg_s;

   typedef struct packed {
      logic cs;
      logic sync_quality_indication;
      logic preamble_quality_indication;
   } qual_s;

   typedef struct packed {
      logic [7:0] peer_address;
      logic [7:0] own_address;
      logic [1:0] tx_seq;
      logic no_ack_flag;
      logic rc_osc_autocal_en;
      logic synth_osc_autocal_en;
      logic duty_cycle_en;
      logic wake_timer_reload_on_sync;
      logic ack_payload_en;
      logic channel_access_en;
      logic channel_access_persistent;
      logic backoff_en;
      logic auto_filter_en;
      logic [3:0] max_retransmissions;
      logic retransmit_en;
      logic auto_ack_en;
      logic persistent_receive_en;
      logic persistent_transmit_en;
   } proto_cfg_s;
endpackage
`default_nettype wire

// File: rtl/rx_accept_filter.sv
// combinational acceptance check of one received packet header
`default_nettype none
module rx_accept_filter
   import rx_cfg_pkg::*;
(
   // configuration and packet
   input wire filter_cfg_s cfg,
   input wire rx_pkt_s pkt,
   // verdict
   output logic accept
);
   function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
      masked_eq = ((a ^ b) & m) == 8'h00;
   endfunction

   logic dest_ok;
   logic source_ok;
   logic ctrl_ok;

   always_comb begin
      // with no destination check enabled any destination passes
      dest_ok = !(cfg.own_en || cfg.group_en || cfg.all_en);
      if (cfg.own_en && pkt.dest == cfg.own) begin
         dest_ok = 1'b1;
      end
      if (cfg.group_en && pkt.dest == cfg.group) begin
         dest_ok = 1'b1;
      end
      if (cfg.all_en && pkt.dest == cfg.all) begin
         dest_ok = 1'b1;
      end
      // a zero mask compares nothing, so it never filters
      source_ok = !cfg.source_en || masked_eq(pkt.source, cfg.peer, cfg.source_mask);
      ctrl_ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (cfg.ctrl_en && !masked_eq(pkt.ctrl[i], cfg.ctrl_ref[i], cfg.ctrl_mask[i])) begin
            ctrl_ok = 1'b0;
         end
      end
      accept = !(cfg.auto_en && !(dest_ok && source_ok && ctrl_ok));
      if (cfg.crc_check && !pkt.crc_ok) begin
         accept = 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: rtl/rx_timeout_timer.sv
// receive timeout timer qualified by the carrier and quality indications
`default_nettype none
module rx_timeout_timer
   import rx_cfg_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // settings
   input wire logic [7:0] prescale,
   input wire logic [7:0] count,
   input wire logic or_select,
   input wire qual_s gate,
   // receiver events
   input wire logic rx_start,
   input wire logic rx_leave,
   input wire qual_s qual,
   // expiry pulse
   output logic expired
);
   typedef enum logic [1:0] {TO_IDLE = 2'b01, TO_RUN = 2'b10} to_state_e;
   typedef struct packed {
      to_state_e st;
      logic [TICK_W-1:0] tick;
      logic [7:0] pre;
      logic [7:0] cnt;
      logic expired;
   } to_s;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   to_s s_reg;
   to_s s_next;
   logic [2:0] masked;
   logic stop_q;

   always_comb begin
      masked = {qual.cs & gate.cs, qual.sync_quality_indication & gate.sync_quality_indication, qual.preamble_quality_indication & gate.preamble_quality_indication};
      // or-mode stops on any gated indication, and-mode only when all gated ones hold
      stop_q = or_select ? (|masked) : ((|gate) && masked == gate);
      s_next = s_reg;
      s_next.expired = 1'b0;
      case (s_reg.st)
         TO_IDLE: begin
            // a zero count leaves the timer disabled
            if (rx_start && count != 8'h00) begin
               s_next.st = TO_RUN;
               s_next.tick = TICK_LAST;
               s_next.pre = prescale;
               s_next.cnt = count;
            end
         end
         TO_RUN: begin
            if (rx_leave || stop_q) begin
               s_next.st = TO_IDLE;
            end else if (s_reg.tick != '0) begin
               s_next.tick = s_reg.tick - 1'b1;
            end else begin
               // one prescaler period of ticks per count step
               s_next.tick = TICK_LAST;
               if (s_reg.pre > 8'h01) begin
                  s_next.pre = s_reg.pre - 8'h01;
               end else if (s_reg.cnt == 8'h01) begin
                  s_next.st = TO_IDLE;
                  s_next.expired = 1'b1;
               end else begin
                  s_next.pre = prescale;
                  s_next.cnt = s_reg.cnt - 8'h01;
               end
            end
         end
         default: s_next.st = TO_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         s_reg <= '{st: TO_IDLE, tick: '0, pre: 8'h00, cnt: 8'h00, expired: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign expired = s_reg.expired;

   qual_stop_a: assert property (@(posedge clock) disable iff (reset)
      (s_reg.st == TO_RUN && stop_q && !rx_leave) |=> (s_reg.st == TO_IDLE && !expired))
      else $error("qualified indication did not stop the timeout");
   expire_run_a: assert property (@(posedge clock) disable iff (reset)
      expired |-> ($past(s_reg.st) == TO_RUN && $past(s_reg.cnt) == 8'h01))
      else $error("timeout expired outside a run");
   expire_cov: cover property (@(posedge clock) disable iff (reset) expired);
endmodule
`default_nettype wire

// File: rtl/rx_filter_cfg.sv
// register bank, acceptance filter and protocol options of the receive filter, reached over AHB-Lite
//
// Functional notes
// - zero control mask byte disables that byte's check
// - four control references, bytes three down to zero
// - peer address: expected source, transmit destination
// - own address: transmit source, expected destination
// - all-stations check accepts all-stations destination
// - group check accepts group destination
// - own check accepts own destination
// - source filter compares under mask; zero mask passes
// - control filter compares bytes under their masks
// - CRC check discards packets with bad CRC
// - or-select combines gated indications with OR
// - three gates choose contributing quality indications
// - sequence reset loads the two-bit preset
// - RC and synthesizer oscillator calibration enables
// - duty cycle enable; wake reload on sync
// - seed reload bit reloads back-off seed
// - channel access enable and persistent variant
// - auto filter enable applies the checks
// - retransmission limit; zero disables retransmission
// - no-ack request sets no-ack in packets
// - persistent receive and transmit enables
// - timeout prescaler and counter; expiry leaves receive
//
// Our own choice: the AHB-Lite slave port.
`default_nettype none
module rx_filter_cfg
   import rx_cfg_pkg::*;
#(
   parameter int ADDR_W = 10
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // received packet check
   input wire logic rx_pkt_valid,
   input wire rx_pkt_s rx_pkt,
   output logic pkt_done,
   output logic pkt_accept,
   // receive timeout
   input wire logic rx_start,
   input wire logic rx_leave,
   input wire qual_s rx_qual,
   output logic rx_timeout_expired,
   // protocol events
   input wire logic seq_reset_cmd,
   input wire logic tx_pkt_sent,
   input wire logic sync_detected,
   output logic seed_reload,
   output logic wake_timer_reload,
   // protocol settings
   output proto_cfg_s proto_cfg
);
   typedef struct packed {
      logic [NUM_REGS-1:0][7:0] regs;
      logic wr_pend;
      logic [SLOT_W-1:0] wr_slot;
      logic [31:0] rdata;
      logic pkt_done;
      logic pkt_accept;
      logic [1:0] tx_seq;
      logic seed_pulse;
      logic wake_pulse;
   } main_state_s;

   function automatic logic [SLOT_W-1:0] slot_of(input logic [6:0] idx);
      logic [6:0] d;
      d = idx - IDX_CTRL_MASK0;
      slot_of = d[SLOT_W-1:0];
   endfunction

   function automatic logic [NUM_REGS-1:0][7:0] reset_regs();
      logic [NUM_REGS-1:0][7:0] r;
      r = '0;
      r[slot_of(IDX_FILTER_OPTIONS)] = RST_FILTER_OPTIONS;
      r[slot_of(IDX_PROTOCOL_HI)] = RST_PROTOCOL_HI;
      r[slot_of(IDX_PROTOCOL_MID)] = RST_ZERO;
      r[slot_of(IDX_PROTOCOL_LO)] = RST_PROTOCOL_LO;
      r[slot_of(IDX_TIMEOUT_PRESCALE)] = RST_TIMEOUT_PRESCALE;
      reset_regs = r;
   endfunction

   localparam logic [SLOT_W-1:0] S_OPT = slot_of(IDX_FILTER_OPTIONS);
   localparam logic [SLOT_W-1:0] S_HI = slot_of(IDX_PROTOCOL_HI);
   localparam logic [SLOT_W-1:0] S_MID = slot_of(IDX_PROTOCOL_MID);
   localparam logic [SLOT_W-1:0] S_LO = slot_of(IDX_PROTOCOL_LO);

   main_state_s s_reg;
   main_state_s s_next;
   logic [ADDR_W-3:0] a_word;
   logic [6:0] a_idx;
   logic a_hit;
   logic a_take;
   logic [SLOT_W-1:0] a_slot;
   logic [7:0] opt;
   logic [7:0] hi;
   logic [7:0] mid;
   logic [7:0] lo;
   filter_cfg_s fcfg;
   logic accept;

   assign opt = s_reg.regs[S_OPT];
   assign hi = s_reg.regs[S_HI];
   assign mid = s_reg.regs[S_MID];
   assign lo = s_reg.regs[S_LO];

   // address phase decode: word accesses inside the bank only
   // the whole word address is range-checked so high address bits never alias into the bank
   assign a_word = haddr[ADDR_W-1:2];
   assign a_idx = a_word[6:0];
   assign a_take = hsel && hready && htrans == HTRANS_NONSEQ;
   assign a_hit = haddr[1:0] == 2'h0 && hsize == HSIZE_WORD && a_word >= IDX_CTRL_MASK0
      && a_word <= IDX_TIMEOUT_COUNT;
   assign a_slot = slot_of(a_idx);

   always_comb begin
      fcfg.auto_en = mid[MID_AUTO_FILTER];
      fcfg.crc_check = opt[OPT_CRC_CHECK];
      fcfg.own_en = opt[OPT_OWN];
      fcfg.group_en = opt[OPT_GROUP];
      fcfg.all_en = opt[OPT_ALL_STATIONS];
      fcfg.source_en = opt[OPT_SOURCE];
      fcfg.ctrl_en = opt[OPT_CONTROL];
      fcfg.own = s_reg.regs[slot_of(IDX_OWN_ADDRESS)];
      fcfg.group = s_reg.regs[slot_of(IDX_GROUP_ADDRESS)];
      fcfg.all = s_reg.regs[slot_of(IDX_ALL_STATIONS)];
      fcfg.peer = s_reg.regs[slot_of(IDX_PEER_ADDRESS)];
      fcfg.source_mask = s_reg.regs[slot_of(IDX_PEER_SOURCE_MASK)];
      // references sit at rising addresses for falling byte numbers
      fcfg.ctrl_ref = {s_reg.regs[slot_of(IDX_CTRL_REF3)], s_reg.regs[slot_of(IDX_CTRL_REF2)],
         s_reg.regs[slot_of(IDX_CTRL_REF1)], s_reg.regs[slot_of(IDX_CTRL_REF0)]};
      fcfg.ctrl_mask = {s_reg.regs[slot_of(IDX_CTRL_MASK3)], s_reg.regs[slot_of(IDX_CTRL_MASK2)],
         s_reg.regs[slot_of(IDX_CTRL_MASK1)], s_reg.regs[slot_of(IDX_CTRL_MASK0)]};
   end

   rx_accept_filter u_filter (
      .cfg(fcfg),
      .pkt(rx_pkt),
      .accept(accept)
   );

   rx_timeout_timer u_timeout (
      .clock(clock),
      .reset(reset),
      .prescale(s_reg.regs[slot_of(IDX_TIMEOUT_PRESCALE)]),
      .count(s_reg.regs[slot_of(IDX_TIMEOUT_COUNT)]),
      .or_select(opt[OPT_OR_SELECT]),
      .gate('{cs: hi[HI_CS_GATE], sync_quality_indication: hi[HI_SQI_GATE], preamble_quality_indication: hi[HI_PQI_GATE]}),
      .rx_start(rx_start),
      .rx_leave(rx_leave),
      .qual(rx_qual),
      .expired(rx_timeout_expired)
   );

   always_comb begin
      s_next = s_reg;
      s_next.seed_pulse = 1'b0;
      s_next.rdata = 32'h0000_0000;
      // data phase of a write lands here, one cycle after its address phase
      if (s_reg.wr_pend) begin
         s_next.regs[s_reg.wr_slot] = hwdata[7:0];
         if (s_reg.wr_slot == S_MID && hwdata[MID_SEED]) begin
            s_next.seed_pulse = 1'b1;
         end
      end
      s_next.wr_pend = a_take && hwrite && a_hit;
      s_next.wr_slot = a_slot;
      if (a_take && !hwrite && a_hit) begin
         // forward a write still in its data phase so a read right behind it is not stale
         if (s_reg.wr_pend && s_reg.wr_slot == a_slot) begin
            s_next.rdata = {24'h00_0000, hwdata[7:0]};
         end else begin
            s_next.rdata = {24'h00_0000, s_reg.regs[a_slot]};
         end
      end
      s_next.pkt_done = rx_pkt_valid;
      s_next.pkt_accept = rx_pkt_valid && accept;
      if (seq_reset_cmd) begin
         s_next.tx_seq = hi[HI_SEQ_MSB:HI_SEQ_LSB];
      end else if (tx_pkt_sent) begin
         s_next.tx_seq = s_reg.tx_seq + 2'h1;
      end
      s_next.wake_pulse = sync_detected && hi[HI_DUTY] && mid[MID_RELOAD_SYNC];
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         s_reg <= '{regs: reset_regs(), wr_pend: 1'b0, wr_slot: '0, rdata: 32'h0000_0000,
            pkt_done: 1'b0, pkt_accept: 1'b0, tx_seq: 2'h0, seed_pulse: 1'b0, wake_pulse: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // zero-wait slave: every transfer completes OKAY, unmapped reads give zero
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_reg.rdata;
   assign pkt_done = s_reg.pkt_done;
   assign pkt_accept = s_reg.pkt_accept;
   assign seed_reload = s_reg.seed_pulse;
   assign wake_timer_reload = s_reg.wake_pulse;

   always_comb begin
      proto_cfg.peer_address = fcfg.peer;
      proto_cfg.own_address = fcfg.own;
      proto_cfg.tx_seq = s_reg.tx_seq;
      proto_cfg.no_ack_flag = lo[LO_NO_ACK];
      proto_cfg.rc_osc_autocal_en = hi[HI_RC_CAL];
      proto_cfg.synth_osc_autocal_en = hi[HI_SYNTH_CAL];
      proto_cfg.duty_cycle_en = hi[HI_DUTY];
      proto_cfg.wake_timer_reload_on_sync = mid[MID_RELOAD_SYNC];
      proto_cfg.ack_payload_en = mid[MID_ACK_PAYLOAD];
      proto_cfg.channel_access_en = mid[MID_ACCESS];
      proto_cfg.channel_access_persistent = mid[MID_PERSISTENT];
      // the persistent variant never backs off
      proto_cfg.backoff_en = mid[MID_ACCESS] && !mid[MID_PERSISTENT];
      proto_cfg.auto_filter_en = mid[MID_AUTO_FILTER];
      proto_cfg.max_retransmissions = lo[LO_RETX_MSB:LO_RETX_LSB];
      proto_cfg.retransmit_en = lo[LO_RETX_MSB:LO_RETX_LSB] != 4'h0;
      proto_cfg.auto_ack_en = lo[LO_AUTO_ACK];
      proto_cfg.persistent_receive_en = lo[LO_PERSISTENT_RECEIVE_EN];
      proto_cfg.persistent_transmit_en = lo[LO_PERSISTENT_TRANSMIT_EN];
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   unmapped_read_a: assert property ((a_take && !hwrite && !a_hit) |=> hrdata == 32'h0000_0000)
      else $error("unmapped read returned nonzero data");
   reset_values_a: assert property ($fell(reset) |-> (opt == RST_FILTER_OPTIONS && lo == RST_PROTOCOL_LO))
      else $error("option bytes wrong after reset");
   seq_preset_a: assert property (seq_reset_cmd |=> proto_cfg.tx_seq == $past(hi[HI_SEQ_MSB:HI_SEQ_LSB]))
      else $error("sequence preset not loaded");
   retx_zero_a: assert property (proto_cfg.retransmit_en == (proto_cfg.max_retransmissions != 4'h0))
      else $error("retransmission enable disagrees with limit");
   wake_reload_a: assert property ((sync_detected && proto_cfg.duty_cycle_en
      && proto_cfg.wake_timer_reload_on_sync) |=> wake_timer_reload)
      else $error("wake timer reload missing after sync");
   seed_pulse_a: assert property ((a_take && hwrite && a_hit && a_slot == S_MID) ##1 hwdata[MID_SEED]
      |=> seed_reload)
      else $error("seed reload pulse missing");
   crc_drop_a: assert property ((rx_pkt_valid && opt[OPT_CRC_CHECK] && !rx_pkt.crc_ok)
      |=> (pkt_done && !pkt_accept))
      else $error("packet with bad crc accepted");
   own_dest_a: assert property ((rx_pkt_valid && fcfg.auto_en && fcfg.own_en && !fcfg.source_en
      && !fcfg.ctrl_en && rx_pkt.crc_ok && rx_pkt.dest == fcfg.own) |=> pkt_accept)
      else $error("packet to own address refused");
   source_drop_a: assert property ((rx_pkt_valid && fcfg.auto_en && fcfg.source_en
      && ((rx_pkt.source ^ fcfg.peer) & fcfg.source_mask) != 8'h00) |=> !pkt_accept)
      else $error("packet from wrong source accepted");
   no_filter_a: assert property ((rx_pkt_valid && !fcfg.auto_en && !fcfg.crc_check) |=> pkt_accept)
      else $error("packet refused with filtering off");

   accept_cov: cover property (rx_pkt_valid && fcfg.auto_en ##1 pkt_accept);
   refuse_cov: cover property (pkt_done && !pkt_accept);
   seed_cov: cover property (seed_reload);
endmodule
`default_nettype wire

// File: testbench/rx_filter_cfg_tb.sv
// self-checking bench of the receive filter configuration bank
`default_nettype none
module rx_filter_cfg_tb import rx_cfg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b1;
   logic [9:0] haddr = 10'h000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = HSIZE_WORD;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rdat;
   logic hreadyout, hresp, pkt_done, pkt_accept, rx_timeout_expired, seed_reload, wake_timer_reload;
   logic rx_pkt_valid = 1'b0, rx_start = 1'b0, rx_leave = 1'b0;
   logic seq_reset_cmd = 1'b0, tx_pkt_sent = 1'b0, sync_detected = 1'b0;
   rx_pkt_s rx_pkt = '0;
   qual_s rx_qual = '0;
   proto_cfg_s proto_cfg;
   logic [7:0] e;
   int n_mismatch = 0;
   int tests_run = 0;
   // setup writes {index, data}; the index 0x45 mask only lets the top nibble of control byte 3 count
   logic [15:0] wr_tab [10] = '{16'h4F7F, 16'h5101, 16'h4E11, 16'h4D22, 16'h4CFF, 16'h4B55, 16'h4AF0,
      16'h46A0, 16'h45F0, 16'h4933};
   // rows {dest, source, control byte 3, crc_ok, accepted}
   logic [25:0] rows [7] = '{{8'h11, 8'h5A, 8'hA7, 2'b11}, {8'h22, 8'h50, 8'hAF, 2'b11},
      {8'hFF, 8'h5F, 8'hA0, 2'b11}, {8'h33, 8'h55, 8'hA0, 2'b10}, {8'h11, 8'h65, 8'hA0, 2'b10},
      {8'h11, 8'h55, 8'hB0, 2'b10}, {8'h11, 8'h55, 8'hA0, 2'b00}};

   always #2 clock = ~clock;

   rx_filter_cfg #(.ADDR_W(10)) i_dut (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_pkt_valid(rx_pkt_valid), .rx_pkt(rx_pkt),
      .pkt_done(pkt_done), .pkt_accept(pkt_accept), .rx_start(rx_start), .rx_leave(rx_leave),
      .rx_qual(rx_qual), .rx_timeout_expired(rx_timeout_expired), .seq_reset_cmd(seq_reset_cmd),
      .tx_pkt_sent(tx_pkt_sent), .sync_detected(sync_detected), .seed_reload(seed_reload),
      .wake_timer_reload(wake_timer_reload), .proto_cfg(proto_cfg));

   task automatic wrap_up;
      if (n_mismatch == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // ends at the rising edge where hready is high; hrdata is caught in the half cycle before it
   task automatic step_ready;
      int n;
      logic r;
      n = 0;
      r = 1'b0;
      while (!r) begin
         @(negedge clock);
         r = (hreadyout === 1'b1);
         rdat = hrdata;
         @(posedge clock);
         n++;
         if (n > 20) begin
            n_mismatch++;
            wrap_up();
         end
      end
   endtask

   task automatic bus(input logic wr, input logic [6:0] i, input logic [7:0] d);
      haddr <= {1'b0, i, 2'b00};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      step_ready();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      step_ready();
   endtask

   task automatic pkt(input logic [25:0] r);
      rx_pkt <= {r[25:10], r[9:2], 24'h999999, r[1]};
      rx_pkt_valid <= 1'b1;
      @(posedge clock);
      rx_pkt_valid <= 1'b0;
      @(negedge clock);
      check({pkt_done, pkt_accept}, {1'b1, r[0]});
      @(posedge clock);
   endtask

   // one tick is 250 cycles, so prescale 1 and count 2 expire near cycle 500
   task automatic run_timeout(input logic exp);
      int n;
      n = 0;
      rx_start <= 1'b1;
      @(posedge clock);
      rx_start <= 1'b0;
      while (rx_timeout_expired !== 1'b1 && n < 600) begin
         @(negedge clock);
         n++;
      end
      check(rx_timeout_expired === 1'b1 && n > 490 && n < 560, exp);
      @(posedge clock);
      rx_leave <= 1'b1;
      @(posedge clock);
      rx_leave <= 1'b0;
   endtask

   initial begin
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      for (int i = 'h42; i <= 'h55; i++) begin
         e = (i == 'h4F) ? 8'h70 : (i == 'h50) ? 8'h02 : (i == 'h52) ? 8'h08 : (i == 'h53) ? 8'h01 : 8'h00;
         bus(1'b0, i[6:0], 8'h00);
         check(rdat, {24'h0, e});
      end
      foreach (wr_tab[k]) bus(1'b1, wr_tab[k][14:8], wr_tab[k][7:0]);
      bus(1'b0, IDX_CTRL_REF0, 8'h00);
      check(rdat, 32'h33);
      check({proto_cfg.peer_address, proto_cfg.own_address, proto_cfg.auto_filter_en}, {16'h5511, 1'b1});
      foreach (rows[k]) pkt(rows[k]);
      // unmapped index: write is dropped, read gives zero
      bus(1'b1, 7'h55, 8'hAA);
      bus(1'b0, 7'h55, 8'h00);
      check(rdat, 32'h0);
      bus(1'b1, IDX_PROTOCOL_MID, 8'h00);
      pkt({8'h33, 8'h65, 8'hB0, 2'b11});
      pkt({8'h11, 8'h55, 8'hA0, 2'b00});
      bus(1'b1, IDX_PROTOCOL_HI, 8'h15);
      seq_reset_cmd <= 1'b1;
      @(posedge clock);
      seq_reset_cmd <= 1'b0;
      @(negedge clock);
      check({proto_cfg.tx_seq, proto_cfg.rc_osc_autocal_en, proto_cfg.duty_cycle_en}, 4'hB);
      @(posedge clock);
      bus(1'b1, IDX_PROTOCOL_MID, 8'h88);
      @(negedge clock);
      check(seed_reload, 1'b1);
      @(posedge clock);
      sync_detected <= 1'b1;
      @(posedge clock);
      sync_detected <= 1'b0;
      @(negedge clock);
      check(wake_timer_reload, 1'b1);
      @(posedge clock);
      bus(1'b1, IDX_PROTOCOL_MID, 8'h06);
      @(negedge clock);
      check({proto_cfg.channel_access_en, proto_cfg.channel_access_persistent, proto_cfg.backoff_en}, 3'h6);
      @(posedge clock);
      bus(1'b1, IDX_PROTOCOL_LO, 8'hF3);
      @(negedge clock);
      check({proto_cfg.max_retransmissions, proto_cfg.retransmit_en, proto_cfg.no_ack_flag,
         proto_cfg.persistent_receive_en, proto_cfg.persistent_transmit_en}, 8'hFB);
      @(posedge clock);
      bus(1'b1, IDX_PROTOCOL_LO, 8'h08);
      @(negedge clock);
      check({proto_cfg.retransmit_en, proto_cfg.no_ack_flag}, 2'h1);
      @(posedge clock);
      bus(1'b1, IDX_TIMEOUT_COUNT, 8'h02);
      run_timeout(1'b1);
      bus(1'b1, IDX_PROTOCOL_HI, 8'h80);
      rx_qual <= 3'b100;
      run_timeout(1'b0);
      // and mode with two gates: carrier sense alone must not hold the timer off
      bus(1'b1, IDX_FILTER_OPTIONS, 8'h3F);
      bus(1'b1, IDX_PROTOCOL_HI, 8'hC0);
      run_timeout(1'b1);
      wrap_up();
   end
endmodule
`default_nettype wire
